// file: rtl/psd_pkg.sv
// psd_pkg: shared constants and carrier types for the port state / dscp block
package psd_pkg;

	// ----------------------------------------------------------------
	// configuration register numbering
	// ----------------------------------------------------------------
	localparam int unsigned DSCP_REG_FIRST = 96;
	localparam int unsigned DSCP_REG_LAST  = 111;
	localparam int unsigned PORT1_CTRL_REG = 18;
	localparam int unsigned PORT2_CTRL_REG = 34;
	localparam int unsigned GLOBAL_CTRL2   = 2;
	localparam int unsigned FLUSH_DYN_BIT  = 5;
	localparam int unsigned FLUSH_STA_BIT  = 4;

	// ----------------------------------------------------------------
	// widths and codes
	// ----------------------------------------------------------------
	localparam int unsigned CODE_POINTS = 64;
	localparam int unsigned CP_W        = 6;
	localparam int unsigned PRIO_W      = 2;
	localparam logic [1:0]  TRL_LOOKUP  = 2'h0;
	localparam logic [1:0]  TRL_PORT1   = 2'h1;
	localparam logic [1:0]  TRL_PORT2   = 2'h2;
	localparam logic [1:0]  TRL_BOTH    = 2'h3;

	// port map bit positions: bit0 port1, bit1 port2, bit2 processor port
	localparam int unsigned PM_P1  = 0;
	localparam int unsigned PM_P2  = 1;
	localparam int unsigned PM_CPU = 2;

	// reset values of per-port controls: port blocked, learning off
	localparam logic        TX_EN_RST  = 1'b0;
	localparam logic        RX_EN_RST  = 1'b0;
	localparam logic        LRN_DIS_RST = 1'b1;
	localparam logic [2:0]  PMAP_RST   = 3'h0;
	localparam logic [1:0]  PRIO_RST   = 2'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic txEnable;
		logic rxEnable;
		logic learnDisable;
	} psd_port_ctrl_t;

	// one frame descriptor from the lookup engine
	typedef struct packed {
		logic [1:0]      srcPort;     // 0 port1, 1 port2, 2 processor
		logic [2:0]      lookupMap;   // ports chosen by address lookup
		logic            staticHit;
		logic            overrideHit;
		logic            hasTrailer;
		logic [1:0]      trailerDest;
		logic            isIp;
		logic [CP_W-1:0] codePoint;
		logic [PRIO_W-1:0] basePrio;
	} psd_frame_t;

	// forwarding decision
	typedef struct packed {
		logic [2:0]        destMap;
		logic              learn;
		logic [PRIO_W-1:0] prio;
	} psd_decision_t;

	typedef enum logic [2:0] {
		PSD_IDLE  = 3'b001,
		PSD_FLUSH = 3'b010,
		PSD_DONE  = 3'b100
	} psd_flush_state_t;

endpackage

// file: rtl/psd_skid_buffer.sv
// psd_skid_buffer: two-entry valid/ready buffer for decisions
`timescale 1ns/1ps
`default_nettype none
module psd_skid_buffer #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 2
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [PW:0]      count;
	wire              doWrite = inValid && inReady;
	wire              doRead  = outValid && outReady;

	// ready drops only when both entries hold words, so a stall loses none
	assign inReady  = (count < (PW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = store[rdPtr];

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doWrite) begin
				wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (doRead) begin
				rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (PW+1)'(doWrite) - (PW+1)'(doRead);
		end
	end

	// data storage needs no reset; valid gates it
	always_ff @(posedge ref_clk) begin
		if (doWrite) begin
			store[wrPtr] <= inData;
		end
	end
endmodule
`default_nettype wire

// file: rtl/psd_port_state.sv
// psd_port_state: spanning tree port gating, flush control, dscp priority
//
// What this block does
// - Code-point map bytes come from configuration registers 96 to 111.
// - The 6-bit code point decodes to 64 cases; its map bit sets priority of IP frames.
// - Port 3 is the processor port; ports 1 and 2 have tree states.
// - Ports 1 and 2 each own tx, rx and learning-disable controls.
// - Enables clear, learning disabled: no user traffic, no learning.
// - Enables clear, learning on: learns, forwards no user traffic.
// - Both enables set, learning on: forwards, receives and learns.
// - A port with enables clear still trades frames with the processor.
// - Override static hits reach the processor from a disabled port.
// - Flush bits 5:4 purge both tables for learning-disabled ports.
// - Trailer bits 1:0 select lookup, port 1, port 2 or both ports.
`timescale 1ns/1ps
`default_nettype none
module psd_port_state #(
	parameter int unsigned MAP_REGS = 16
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	// configuration writes (byte registers)
	input  wire logic                  cfgWrite,
	input  wire logic [7:0]            cfgAddr,
	input  wire logic [7:0]            cfgData,
	// frame descriptors in
	input  wire logic                  frmValid,
	output logic                       frmReady,
	input  wire psd_pkg::psd_frame_t   frmDesc,
	// decisions out
	output logic                       decValid,
	input  wire logic                  decReady,
	output psd_pkg::psd_decision_t     decOut,
	// address table flush handshake
	output logic                       flushReq,
	output logic [1:0]                 flushPorts,
	output logic                       flushDynamic,
	output logic                       flushStatic,
	input  wire logic                  flushAck,
	// status
	output logic [1:0]                 portForwarding,
	output logic                       flushBusy
);
	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0]                 dscpMap [MAP_REGS];
	psd_pkg::psd_port_ctrl_t    portCtrl [2];
	logic [7:0]                 globalCtrl2;

	wire [7:0] mapOffset = cfgAddr - 8'(psd_pkg::DSCP_REG_FIRST);
	wire       mapHit    = cfgWrite
		&& (cfgAddr >= 8'(psd_pkg::DSCP_REG_FIRST))
		&& (cfgAddr <= 8'(psd_pkg::DSCP_REG_LAST));
	wire       p1Hit = cfgWrite && (cfgAddr == 8'(psd_pkg::PORT1_CTRL_REG));
	wire       p2Hit = cfgWrite && (cfgAddr == 8'(psd_pkg::PORT2_CTRL_REG));
	wire       g2Hit = cfgWrite && (cfgAddr == 8'(psd_pkg::GLOBAL_CTRL2));

	// control bits of the port registers sit in bits 2:0 of the byte
	function automatic psd_pkg::psd_port_ctrl_t unpackCtrl(
		input logic [7:0] b
	);
		unpackCtrl = '{txEnable: b[2], rxEnable: b[1], learnDisable: b[0]};
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < MAP_REGS; gi++) begin : gMap
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					dscpMap[gi] <= 8'h00;
				end else if (mapHit && mapOffset[3:0] == 4'(gi)) begin
					dscpMap[gi] <= cfgData;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			portCtrl[0] <= '{psd_pkg::TX_EN_RST, psd_pkg::RX_EN_RST,
				psd_pkg::LRN_DIS_RST};
			portCtrl[1] <= '{psd_pkg::TX_EN_RST, psd_pkg::RX_EN_RST,
				psd_pkg::LRN_DIS_RST};
		end else begin
			if (p1Hit) begin
				portCtrl[0] <= unpackCtrl(cfgData);
			end
			if (p2Hit) begin
				portCtrl[1] <= unpackCtrl(cfgData);
			end
		end
	end

	// ----------------------------------------------------------------
	// rapid flush
	// ----------------------------------------------------------------
	psd_pkg::psd_flush_state_t flushState;
	psd_pkg::psd_flush_state_t next_flushState;
	wire flushDyn = globalCtrl2[psd_pkg::FLUSH_DYN_BIT];
	wire flushSta = globalCtrl2[psd_pkg::FLUSH_STA_BIT];
	wire flushGo  = flushDyn && flushSta
		&& (portCtrl[0].learnDisable || portCtrl[1].learnDisable);

	always_comb begin
		next_flushState = flushState;
		case (flushState)
			psd_pkg::PSD_IDLE: begin
				if (flushGo) begin
					next_flushState = psd_pkg::PSD_FLUSH;
				end
			end
			psd_pkg::PSD_FLUSH: begin
				if (flushAck) begin
					next_flushState = psd_pkg::PSD_DONE;
				end
			end
			psd_pkg::PSD_DONE: begin
				next_flushState = psd_pkg::PSD_IDLE;
			end
			default: begin
				next_flushState = psd_pkg::PSD_IDLE;
			end
		endcase
	end

	// the flush bits self-clear in PSD_DONE, the cycle after the table engine acknowledges;
	// a software write in that same cycle wins so no request is lost
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			globalCtrl2 <= 8'h00;
		end else if (g2Hit) begin
			globalCtrl2 <= cfgData;
		end else if (flushState == psd_pkg::PSD_DONE) begin
			globalCtrl2[psd_pkg::FLUSH_DYN_BIT] <= 1'b0;
			globalCtrl2[psd_pkg::FLUSH_STA_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flushState   <= psd_pkg::PSD_IDLE;
			flushReq     <= 1'b0;
			flushPorts   <= 2'h0;
			flushDynamic <= 1'b0;
			flushStatic  <= 1'b0;
			flushBusy    <= 1'b0;
		end else begin
			flushState   <= next_flushState;
			flushReq     <= (next_flushState == psd_pkg::PSD_FLUSH);
			flushBusy    <= (next_flushState != psd_pkg::PSD_IDLE);
			if (flushState == psd_pkg::PSD_IDLE && flushGo) begin
				flushPorts   <= {portCtrl[1].learnDisable,
					portCtrl[0].learnDisable};
				flushDynamic <= 1'b1;
				flushStatic  <= 1'b1;
			end else if (next_flushState == psd_pkg::PSD_IDLE) begin
				flushDynamic <= 1'b0;
				flushStatic  <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// forwarding decision
	// ----------------------------------------------------------------
	// a port passes user traffic only with both enables set
	function automatic logic userOpen(input psd_pkg::psd_port_ctrl_t c);
		userOpen = c.txEnable && c.rxEnable;
	endfunction

	wire        fromCpu  = (frmDesc.srcPort == 2'h2);
	wire        fromP2   = (frmDesc.srcPort == 2'h1);
	psd_pkg::psd_port_ctrl_t srcCtrl;
	assign srcCtrl = fromP2 ? portCtrl[1] : portCtrl[0];
	wire        srcOpen  = userOpen(srcCtrl);

	// processor-originated frames: trailer steers, blocked ports still
	// reachable so tree control frames get out
	wire [2:0]  trlMap =
		(frmDesc.trailerDest == psd_pkg::TRL_PORT1) ? 3'h1 :
		(frmDesc.trailerDest == psd_pkg::TRL_PORT2) ? 3'h2 :
		(frmDesc.trailerDest == psd_pkg::TRL_BOTH)  ? 3'h3 : 3'h0;
	wire        useTrl   = frmDesc.hasTrailer
		&& (frmDesc.trailerDest != psd_pkg::TRL_LOOKUP);
	wire [2:0]  openMask = {1'b1, userOpen(portCtrl[1]),
		userOpen(portCtrl[0])};
	wire [2:0]  cpuMap   = useTrl ? trlMap
		: (frmDesc.lookupMap & openMask);

	// port-originated frames: user traffic only when open, otherwise
	// only processor-bound frames pass, plus override hits
	wire [2:0]  portMap  = srcOpen
		? (frmDesc.lookupMap & openMask)
		: (frmDesc.lookupMap & 3'h4);
	wire [2:0]  ovrMap   = (frmDesc.staticHit && frmDesc.overrideHit)
		? 3'h4 : 3'h0;
	wire [2:0]  destMap  = fromCpu ? cpuMap : (portMap | ovrMap);

	wire        learnOk  = !fromCpu && !srcCtrl.learnDisable;

	// full decode of the code point; each map byte holds four code points in bits 3:0, bit 0 the lowest
	localparam int unsigned CODE_POINTS_W = psd_pkg::CODE_POINTS;
	wire [CODE_POINTS_W-1:0] cpOneHot = 64'h1 << frmDesc.codePoint;
	logic [CODE_POINTS_W-1:0] mapFlat;
	generate
		for (gi = 0; gi < MAP_REGS; gi++) begin : gFlat
			assign mapFlat[gi*4 +: 4] = dscpMap[gi][3:0];
		end
	endgenerate
	wire        mapBit   = |(cpOneHot & mapFlat);
	// ip frames take the map result as the high priority class
	wire [psd_pkg::PRIO_W-1:0] prio = frmDesc.isIp
		? (mapBit ? 2'h3 : frmDesc.basePrio)
		: frmDesc.basePrio;

	psd_pkg::psd_decision_t decIn;
	assign decIn = '{destMap: destMap, learn: learnOk, prio: prio};

	psd_skid_buffer #(
		.WIDTH ($bits(psd_pkg::psd_decision_t)),
		.DEPTH (2)
	) uBuf (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.inValid  (frmValid),
		.inReady  (frmReady),
		.inData   (decIn),
		.outValid (decValid),
		.outReady (decReady),
		.outData  (decOut)
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			portForwarding <= 2'h0;
		end else begin
			portForwarding <= {userOpen(portCtrl[1]), userOpen(portCtrl[0])};
		end
	end
endmodule
`default_nettype wire

// file: dv/psd_port_state_sva.sv
// psd_port_state_sva: port-level assertions for the port state block
`timescale 1ns/1ps
`default_nettype none
module psd_port_state_sva (
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   sys_rst,
	// configuration
	input wire logic                   cfgWrite,
	input wire logic [7:0]             cfgAddr,
	input wire logic [7:0]             cfgData,
	// frames and decisions
	input wire logic                   frmValid,
	input wire logic                   frmReady,
	input wire psd_pkg::psd_frame_t    frmDesc,
	input wire logic                   decValid,
	input wire logic                   decReady,
	input wire psd_pkg::psd_decision_t decOut,
	// flush and status
	input wire logic                   flushReq,
	input wire logic [1:0]             flushPorts,
	input wire logic                   flushDynamic,
	input wire logic                   flushStatic,
	input wire logic                   flushAck,
	input wire logic [1:0]             portForwarding,
	input wire logic                   flushBusy
);
	// shadow controls hold the pre-write value at a same-edge write
	logic [2:0]  ctl1;
	logic [2:0]  ctl2;
	logic [63:0] cpMap;
	wire logic [2:0] om = {1'b1, &ctl2[2:1], &ctl1[2:1]};
	// accepted word heads the buffer next cycle: empty, or head leaving
	wire logic take = frmValid && frmReady && (!decValid || decReady);
	wire logic cpu = frmDesc.srcPort == 2'h2;
	wire logic open = om[frmDesc.srcPort[0]];
	wire logic trl = frmDesc.hasTrailer && frmDesc.trailerDest != 2'h0;
	wire logic expLearn = !cpu && !(frmDesc.srcPort[0] ? ctl2[0] : ctl1[0]);
	wire logic [1:0] expPrio = (frmDesc.isIp && cpMap[frmDesc.codePoint]) ?
		2'h3 : frmDesc.basePrio;
	wire logic [2:0] expDest = (cpu && trl) ? {1'b0, frmDesc.trailerDest} :
		(cpu || open) ? frmDesc.lookupMap & om :
		(frmDesc.lookupMap & 3'h4) |
		{frmDesc.staticHit && frmDesc.overrideHit, 2'h0};
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctl1  <= 3'h1;
			ctl2  <= 3'h1;
			cpMap <= 64'h0;
		end else if (cfgWrite) begin
			if (cfgAddr == 8'h12) ctl1 <= cfgData[2:0];
			if (cfgAddr == 8'h22) ctl2 <= cfgData[2:0];
			if (cfgAddr[7:4] == 4'h6) cpMap[4*cfgAddr[3:0] +: 4] <= cfgData[3:0];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	AST_LATENCY: assert property (frmValid && frmReady |=> decValid)
		else $error("decision missing one cycle after accept");
	AST_HOLD: assert property (decValid && !decReady |=> decValid && $stable(decOut))
		else $error("decision dropped or changed under stall");
	AST_LEARN: assert property (take |=> decOut.learn == $past(expLearn))
		else $error("learn flag wrong");
	AST_CLOSED: assert property (take && !cpu && !open |=> decOut.destMap == $past(expDest))
		else $error("closed port destination wrong");
	AST_OPEN: assert property (take && !cpu && open |=> decOut.destMap == $past(expDest))
		else $error("open port destination wrong");
	AST_TRAILER: assert property (take && cpu && trl |=> decOut.destMap == $past(expDest))
		else $error("trailer steering wrong");
	AST_CPU_LOOKUP: assert property (take && cpu && !trl |=> decOut.destMap == $past(expDest))
		else $error("processor lookup destination wrong");
	AST_PRIO: assert property (take |=> decOut.prio == $past(expPrio))
		else $error("priority wrong");
	AST_FLUSH_GO: assert property (cfgWrite && cfgAddr == 8'h02
		&& &cfgData[5:4] && (ctl1[0] || ctl2[0]) && !flushBusy
		|=> ##1 flushReq && flushBusy && flushDynamic && flushStatic
		&& flushPorts == {ctl2[0], ctl1[0]})
		else $error("flush did not start");
	AST_FLUSH_END: assert property (flushReq && flushAck |=> !flushReq ##1 (!flushBusy && !flushDynamic && !flushStatic))
		else $error("flush did not end");
	COV_TRL: cover property (take && cpu && trl);
	COV_STALL: cover property (decValid && !decReady ##1 decValid);
	COV_FLUSH: cover property (flushReq && flushAck);
endmodule
bind psd_port_state psd_port_state_sva u_sva (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .cfgWrite(cfgWrite),
	.cfgAddr(cfgAddr), .cfgData(cfgData), .frmValid(frmValid),
	.frmReady(frmReady), .frmDesc(frmDesc), .decValid(decValid),
	.decReady(decReady), .decOut(decOut), .flushReq(flushReq),
	.flushPorts(flushPorts), .flushDynamic(flushDynamic),
	.flushStatic(flushStatic), .flushAck(flushAck),
	.portForwarding(portForwarding), .flushBusy(flushBusy)
);
`default_nettype wire

// file: dv/psd_table_model.sv
// psd_table_model: address table engine and decision sink beside the block
`timescale 1ns/1ps
`default_nettype none
module psd_table_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// flush handshake
	input  wire logic       flushReq,
	input  wire logic [3:0] ackDly,
	output logic            flushAck,
	// decision sink
	input  wire logic       stall,
	output logic            decReady
);
	logic [4:0] cnt;
	// sink stalls on command so the two-entry buffer fills
	assign decReady = !stall;
	// one ack pulse per request; ackDly lets the engine be slow
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !flushReq) begin
			cnt      <= 5'h00;
			flushAck <= 1'b0;
		end else begin
			cnt      <= cnt + 5'h01;
			flushAck <= cnt == {1'b0, ackDly};
		end
	end
endmodule
`default_nettype wire

// file: dv/psd_port_state_tb.sv
// psd_port_state_tb: self-checking bench for the port state block
`timescale 1ns/1ps
`default_nettype none
module psd_port_state_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cfgWrite = 1'b0;
	logic [7:0] cfgAddr = 8'h00;
	logic [7:0] cfgData = 8'h00;
	logic frmValid = 1'b0;
	psd_pkg::psd_frame_t frmDesc = '0;
	logic stall = 1'b0;
	logic [3:0] ackDly = 4'h0;
	logic frmReady, decValid, decReady, flushReq, flushDynamic;
	logic flushStatic, flushAck, flushBusy;
	logic [1:0] flushPorts, portForwarding;
	psd_pkg::psd_decision_t decOut;
	int num_errors = 0;
	int n_tests = 0;
	logic [2:0] ctl1 = 3'h1;
	logic [2:0] ctl2 = 3'h1;
	logic [63:0] cpMap = 64'h0;
	psd_pkg::psd_decision_t expQ [$];
	psd_pkg::psd_frame_t f;
	logic [7:0] st [3] = '{8'h01, 8'h00, 8'h06};
	psd_port_state u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgData(cfgData),
		.frmValid(frmValid), .frmReady(frmReady), .frmDesc(frmDesc),
		.decValid(decValid), .decReady(decReady), .decOut(decOut),
		.flushReq(flushReq), .flushPorts(flushPorts),
		.flushDynamic(flushDynamic), .flushStatic(flushStatic),
		.flushAck(flushAck), .portForwarding(portForwarding),
		.flushBusy(flushBusy));
	psd_table_model u_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.flushReq(flushReq), .ackDly(ackDly), .flushAck(flushAck),
		.stall(stall), .decReady(decReady));
	initial forever #25 ref_clk = ~ref_clk;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		cfgWrite <= 1'b1;
		cfgAddr <= a;
		cfgData <= d;
		@(posedge ref_clk);
		cfgWrite <= 1'b0;
		if (a == 8'h12) ctl1 = d[2:0];
		if (a == 8'h22) ctl2 = d[2:0];
		if (a[7:4] == 4'h6) cpMap[4*a[3:0] +: 4] = d[3:0];
		@(posedge ref_clk);
	endtask
	function automatic psd_pkg::psd_decision_t expect_of(psd_pkg::psd_frame_t g);
		psd_pkg::psd_decision_t r;
		logic [2:0] om;
		logic [2:0] c;
		om = {1'b1, &ctl2[2:1], &ctl1[2:1]};
		c = g.srcPort[0] ? ctl2 : ctl1;
		r.learn = g.srcPort != 2'h2 && !c[0];
		r.prio = (g.isIp && cpMap[g.codePoint]) ? 2'h3 : g.basePrio;
		if (g.srcPort == 2'h2 && g.hasTrailer && g.trailerDest != 2'h0)
			r.destMap = {1'b0, g.trailerDest};
		else if (g.srcPort == 2'h2 || &c[2:1]) r.destMap = g.lookupMap & om;
		else r.destMap = (g.lookupMap & 3'h4) | {g.staticHit && g.overrideHit, 2'h0};
		return r;
	endfunction
	// valid stays up between back-to-back sends; idle lowers it
	task automatic send(psd_pkg::psd_frame_t g);
		int i;
		frmValid <= 1'b1;
		frmDesc <= g;
		expQ.push_back(expect_of(g));
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (frmReady === 1'b1) break;
		end
		if (i == 50) begin num_errors++; give_verdict(); end
	endtask
	task automatic drain();
		int i;
		frmValid <= 1'b0;
		for (i = 0; i < 60 && expQ.size() != 0; i++) @(posedge ref_clk);
		if (expQ.size() != 0) begin num_errors++; give_verdict(); end
	endtask
	task automatic wait_busy(logic lvl);
		int i;
		for (i = 0; i < 40 && flushBusy !== lvl; i++) @(posedge ref_clk);
		if (flushBusy !== lvl) begin num_errors++; give_verdict(); end
	endtask
	always @(posedge ref_clk) begin
		if (!sys_rst && decValid === 1'b1 && decReady === 1'b1) begin
			if (expQ.size() == 0) check("extra decision", 16'h1, 16'h0);
			else check("decision", 16'(decOut), 16'(expQ.pop_front()));
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		check("frmReady", 16'(frmReady), 16'h1);
		check("portForwarding", 16'(portForwarding), 16'h0);
		check("flushBusy", 16'(flushBusy), 16'h0);
		$display("test reset done");
		for (int s = 0; s < 3; s++) begin
			wr(8'h12, st[s]);
			wr(8'h22, st[s]);
			repeat (2) @(posedge ref_clk);
			check("portForwarding", 16'(portForwarding), {14'h0, {2{st[s][2]}}});
			// no processor frames toward a discarding port
			for (int p = 0; p < (s == 0 ? 2 : 3); p++) begin
				f = '0;
				f.srcPort = p[1:0];
				f.lookupMap = (p == 2) ? 3'h3 : 3'h7;
				send(f);
				f.staticHit = 1'b1;
				f.overrideHit = 1'b1;
				send(f);
			end
			drain();
		end
		wr(8'h13, 8'h00);
		repeat (2) @(posedge ref_clk);
		check("unmapped write", 16'(portForwarding), 16'h3);
		$display("test port states done");
		wr(8'h12, 8'h00);
		wr(8'h22, 8'h00);
		for (int t = 0; t < 4; t++) begin
			f = '0;
			f.srcPort = 2'h2;
			f.hasTrailer = 1'b1;
			f.trailerDest = t[1:0];
			f.lookupMap = 3'h3;
			send(f);
		end
		drain();
		$display("test trailer done");
		for (int i = 0; i < 16; i++) wr(8'h60 + 8'(i), {4'hA, 4'(i) ^ 4'h5});
		for (int i = 0; i < 65; i++) begin
			f = '0;
			f.isIp = i < 64;
			f.codePoint = i[5:0];
			f.basePrio = 2'h1;
			send(f);
		end
		drain();
		$display("test code points done");
		stall <= 1'b1;
		fork
			begin send(f); send(f); send(f); drain(); end
			begin
				repeat (6) @(posedge ref_clk);
				check("frmReady full", 16'(frmReady), 16'h0);
				stall <= 1'b0;
			end
		join
		$display("test stall done");
		wr(8'h12, 8'h01);
		for (int d = 0; d < 2; d++) begin
			ackDly <= d ? 4'h6 : 4'h0;
			wr(8'h02, 8'h30);
			wait_busy(1'b1);
			check("flushPorts", 16'(flushPorts), 16'h1);
			check("flushKinds", 16'({flushDynamic, flushStatic}), 16'h3);
			wait_busy(1'b0);
			check("flushReq", 16'(flushReq), 16'h0);
		end
		wr(8'h12, 8'h00);
		wr(8'h02, 8'h30);
		repeat (4) @(posedge ref_clk);
		check("no flush", 16'(flushBusy), 16'h0);
		$display("test flush done");
		give_verdict();
	end
endmodule
`default_nettype wire
